// ==== common/pfs_pkg.sv ====
package pfs_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int          ADDR_W          = 4;
  localparam logic [3:0]  OFS_PA_SEL_LOW  = 4'h0;
  localparam logic [3:0]  OFS_PA_SEL_HIGH = 4'h1;
  localparam logic [3:0]  OFS_PB_SEL_LOW  = 4'h2;
  localparam logic [3:0]  OFS_PB_SEL_HIGH = 4'h3;
  localparam logic [3:0]  OFS_PA_DATA     = 4'h4;
  localparam logic [3:0]  OFS_PA_DIR      = 4'h5;
  localparam logic [3:0]  OFS_PB_DATA     = 4'h6;
  localparam logic [3:0]  OFS_PB_DIR      = 4'h7;
  localparam logic [3:0]  OFS_PA_PIN      = 4'h8;
  localparam logic [3:0]  OFS_PB_PIN      = 4'h9;
  localparam logic [3:0]  OFS_TMR_CTRL    = 4'hA;

  // ------------------------------------------------------------------
  // Reset values and writable masks
  // ------------------------------------------------------------------
  localparam logic [7:0]  RST_SEL         = 8'h00;
  localparam logic [7:0]  RST_PORT        = 8'hFF;
  localparam logic [7:0]  MASK_PA_HIGH    = 8'hF3;
  localparam logic [7:0]  MASK_PB_HIGH    = 8'h03;

  // ------------------------------------------------------------------
  // Field positions (low bit of each two-bit role field)
  // ------------------------------------------------------------------
  localparam int          POS_PIN3        = 6;
  localparam int          POS_PIN2        = 4;
  localparam int          POS_PIN1        = 2;
  localparam int          POS_PIN0        = 0;
  localparam int          POS_PA_PIN7     = 6;
  localparam int          POS_PA_PIN6     = 4;

  // ------------------------------------------------------------------
  // Role codes
  // ------------------------------------------------------------------
  localparam logic [1:0]  CODE_00         = 2'h0;
  localparam logic [1:0]  CODE_01         = 2'h1;
  localparam logic [1:0]  CODE_10         = 2'h2;
  localparam logic [1:0]  CODE_11         = 2'h3;

endpackage : pfs_pkg

// ==== src/pfs_pin_sync.sv ====
`timescale 1ns/1ns
module pfs_pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // Pins in, filtered level out
  input  wire logic [W-1:0] pinRaw,
  output logic      [W-1:0] pinLevel
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ------------------------------------------------------------------
  // Three stages; level moves only when stages two and three agree
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end else begin
      s1_q <= pinRaw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinLevel <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pinLevel[i] <= s3_q[i];
        end
      end
    end
  end

endmodule : pfs_pin_sync

// ==== src/pfs_pin_function_select.sv ====
// Behaviour
// - Port A pin 3: 01 amp positive input
// - Port A pin 2: 01 amp negative, 10 battery
// - Port A pin 1: amp out, analog 1, timer
// - Port A pin 0: interrupt, analog 0, timer
// - Port A pin 7: 01 selects analog input 3
// - Port A pin 6: amp positive, analog 2, inverted
// - Port A high bits 3:2 read zero
// - Port B pin 3: 01 selects touch key two
// - Port B pin 2: touch key one, reference
// - Port B pin 1: 01 inverted timer output
// - Port B pin 0: 01 timer primary output
// - Port B pin 0 signal drives transistor gate
// - Port B high bits 7:2 read zero
// - Port data and direction reset to ones
// - Inverted timer output is primary's complement
`timescale 1ns/1ns
module pfs_pin_function_select
  import pfs_pkg::*;
#(
  parameter int PIN_W = 8
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      srst,
  // Register port
  input  wire logic [pfs_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [7:0]                regWdata,
  input  wire logic                      regWrite,
  input  wire logic                      regRead,
  output logic      [7:0]                regRdata,
  // Peripheral sources
  input  wire logic                      timerPrimary,
  input  wire logic                      ampOutput,
  // Port A pins
  input  wire logic [PIN_W-1:0]          paPinIn,
  output logic      [PIN_W-1:0]          paPinOut,
  output logic      [PIN_W-1:0]          paPinOe,
  output logic      [PIN_W-1:0]          paAnalogEn,
  // Port B pins
  input  wire logic [PIN_W-1:0]          pbPinIn,
  output logic      [PIN_W-1:0]          pbPinOut,
  output logic      [PIN_W-1:0]          pbPinOe,
  output logic      [PIN_W-1:0]          pbAnalogEn,
  // Routed analogue and digital roles
  output logic                           ampPositiveFromPa3,
  output logic                           ampPositiveFromPa6,
  output logic                           ampNegativeSel,
  output logic                           battSenseSel,
  output logic      [3:0]                analogInputSel,
  output logic                           touchKeyOneSel,
  output logic                           touchKeyTwoSel,
  output logic                           vrefSel,
  output logic                           extIntLevel,
  output logic                           nmosGate
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic [7:0] paSelLow_q;
  logic [7:0] paSelHigh_q;
  logic [7:0] pbSelLow_q;
  logic [7:0] pbSelHigh_q;
  logic [7:0] paData_q;
  logic [7:0] paDir_q;
  logic [7:0] pbData_q;
  logic [7:0] pbDir_q;
  logic [7:0] regRdata_d;
  logic [PIN_W-1:0] paLevel;
  logic [PIN_W-1:0] pbLevel;

  logic [1:0] paPin3Role;
  logic [1:0] paPin2Role;
  logic [1:0] paPin1Role;
  logic [1:0] paPin0Role;
  logic [1:0] paPin7Role;
  logic [1:0] paPin6Role;
  logic [1:0] pbPin3Role;
  logic [1:0] pbPin2Role;
  logic [1:0] pbPin1Role;
  logic [1:0] pbPin0Role;

  logic       timerInverted;
  logic [7:0] paPerEn;
  logic [7:0] paPerVal;
  logic [7:0] paAna;
  logic [7:0] pbPerEn;
  logic [7:0] pbPerVal;
  logic [7:0] pbAna;
  logic [7:0] paOut_d;
  logic [7:0] pbOut_d;

  function automatic logic [1:0] roleField(input logic [7:0] r,
                                           input int pos);
    roleField = r[pos +: 2];
  endfunction : roleField

  // ------------------------------------------------------------------
  // Pin input synchroniser
  // ------------------------------------------------------------------
  pfs_pin_sync #(
    .W (2 * PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .srst     (srst),
    .pinRaw   ({pbPinIn, paPinIn}),
    .pinLevel ({pbLevel, paLevel})
  );

  // ------------------------------------------------------------------
  // Selection registers
  // ------------------------------------------------------------------
  // Software keeps the reserved low bits untouched; hardware stores them
  always_ff @(posedge core_clk) begin
    if (srst) begin
      paSelLow_q  <= RST_SEL;
      paSelHigh_q <= RST_SEL;
      pbSelLow_q  <= RST_SEL;
      pbSelHigh_q <= RST_SEL;
    end else if (regWrite) begin
      if (regAddr == OFS_PA_SEL_LOW) begin
        paSelLow_q <= regWdata;
      end else if (regAddr == OFS_PA_SEL_HIGH) begin
        paSelHigh_q <= regWdata & MASK_PA_HIGH;
      end else if (regAddr == OFS_PB_SEL_LOW) begin
        pbSelLow_q <= regWdata;
      end else if (regAddr == OFS_PB_SEL_HIGH) begin
        pbSelHigh_q <= regWdata & MASK_PB_HIGH;
      end
    end
  end

  // ------------------------------------------------------------------
  // Port data and direction registers
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      paData_q <= RST_PORT;
      paDir_q  <= RST_PORT;
      pbData_q <= RST_PORT;
      pbDir_q  <= RST_PORT;
    end else if (regWrite) begin
      if (regAddr == OFS_PA_DATA) begin
        paData_q <= regWdata;
      end else if (regAddr == OFS_PA_DIR) begin
        paDir_q <= regWdata;
      end else if (regAddr == OFS_PB_DATA) begin
        pbData_q <= regWdata;
      end else if (regAddr == OFS_PB_DIR) begin
        pbDir_q <= regWdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    regRdata_d = 8'h00;
    if (regAddr == OFS_PA_SEL_LOW) begin
      regRdata_d = paSelLow_q;
    end else if (regAddr == OFS_PA_SEL_HIGH) begin
      regRdata_d = paSelHigh_q & MASK_PA_HIGH;
    end else if (regAddr == OFS_PB_SEL_LOW) begin
      regRdata_d = pbSelLow_q;
    end else if (regAddr == OFS_PB_SEL_HIGH) begin
      regRdata_d = pbSelHigh_q & MASK_PB_HIGH;
    end else if (regAddr == OFS_PA_DATA) begin
      regRdata_d = paData_q;
    end else if (regAddr == OFS_PA_DIR) begin
      regRdata_d = paDir_q;
    end else if (regAddr == OFS_PB_DATA) begin
      regRdata_d = pbData_q;
    end else if (regAddr == OFS_PB_DIR) begin
      regRdata_d = pbDir_q;
    end else if (regAddr == OFS_PA_PIN) begin
      regRdata_d = paLevel[7:0];
    end else if (regAddr == OFS_PB_PIN) begin
      regRdata_d = pbLevel[7:0];
    end else if (regAddr == OFS_TMR_CTRL) begin
      regRdata_d = {6'h00, timerInverted, timerPrimary};
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      regRdata <= regRdata_d;
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // Role decode
  // ------------------------------------------------------------------
  assign paPin3Role    = roleField(paSelLow_q, POS_PIN3);
  assign paPin2Role    = roleField(paSelLow_q, POS_PIN2);
  assign paPin1Role    = roleField(paSelLow_q, POS_PIN1);
  assign paPin0Role    = roleField(paSelLow_q, POS_PIN0);
  assign paPin7Role    = roleField(paSelHigh_q, POS_PA_PIN7);
  assign paPin6Role    = roleField(paSelHigh_q, POS_PA_PIN6);
  assign pbPin3Role    = roleField(pbSelLow_q, POS_PIN3);
  assign pbPin2Role    = roleField(pbSelLow_q, POS_PIN2);
  assign pbPin1Role    = roleField(pbSelLow_q, POS_PIN1);
  assign pbPin0Role    = roleField(pbSelLow_q, POS_PIN0);
  assign timerInverted = ~timerPrimary;

  always_comb begin
    paPerEn  = 8'h00;
    paPerVal = 8'h00;
    paAna    = 8'h00;
    pbPerEn  = 8'h00;
    pbPerVal = 8'h00;
    pbAna    = 8'h00;
    paAna[3] = (paPin3Role == CODE_01);
    paAna[2] = (paPin2Role == CODE_01) || (paPin2Role == CODE_10);
    case (paPin1Role)
      CODE_01: begin
        paPerEn[1]  = 1'b1;
        paPerVal[1] = ampOutput;
      end
      CODE_10: paAna[1] = 1'b1;
      CODE_11: begin
        paPerEn[1]  = 1'b1;
        paPerVal[1] = timerPrimary;
      end
      default: ;
    endcase
    case (paPin0Role)
      CODE_01: paAna[0] = 1'b1;
      CODE_10: begin
        paPerEn[0]  = 1'b1;
        paPerVal[0] = timerPrimary;
      end
      default: ;
    endcase
    paAna[7] = (paPin7Role == CODE_01);
    case (paPin6Role)
      CODE_01, CODE_10: paAna[6] = 1'b1;
      CODE_11: begin
        paPerEn[6]  = 1'b1;
        paPerVal[6] = timerInverted;
      end
      default: ;
    endcase
    pbAna[3] = (pbPin3Role == CODE_01);
    pbAna[2] = (pbPin2Role == CODE_01) || (pbPin2Role == CODE_10);
    if (pbPin1Role == CODE_01) begin
      pbPerEn[1]  = 1'b1;
      pbPerVal[1] = timerInverted;
    end
    if (pbPin0Role == CODE_01) begin
      pbPerEn[0]  = 1'b1;
      pbPerVal[0] = timerPrimary;
    end
  end

  // Peripheral output roles take over the data latch and drive the pin
  assign paOut_d = (paPerEn & paPerVal) | (~paPerEn & paData_q);
  assign pbOut_d = (pbPerEn & pbPerVal) | (~pbPerEn & pbData_q);

  // ------------------------------------------------------------------
  // Registered pin and role outputs
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      paPinOut   <= '1;
      pbPinOut   <= '1;
      paPinOe    <= '0;
      pbPinOe    <= '0;
      paAnalogEn <= '0;
      pbAnalogEn <= '0;
    end else begin
      paPinOut   <= PIN_W'(paOut_d);
      pbPinOut   <= PIN_W'(pbOut_d);
      paPinOe    <= PIN_W'((paPerEn | ~paDir_q) & ~paAna);
      pbPinOe    <= PIN_W'((pbPerEn | ~pbDir_q) & ~pbAna);
      paAnalogEn <= PIN_W'(paAna);
      pbAnalogEn <= PIN_W'(pbAna);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ampPositiveFromPa3 <= 1'b0;
      ampPositiveFromPa6 <= 1'b0;
      ampNegativeSel     <= 1'b0;
      battSenseSel       <= 1'b0;
      analogInputSel     <= 4'h0;
      touchKeyOneSel     <= 1'b0;
      touchKeyTwoSel     <= 1'b0;
      vrefSel            <= 1'b0;
      extIntLevel        <= 1'b1;
      nmosGate           <= 1'b1;
    end else begin
      ampPositiveFromPa3 <= (paPin3Role == CODE_01);
      ampPositiveFromPa6 <= (paPin6Role == CODE_01);
      ampNegativeSel     <= (paPin2Role == CODE_01);
      battSenseSel       <= (paPin2Role == CODE_10);
      analogInputSel     <= {paPin7Role == CODE_01, paPin6Role == CODE_10,
                             paPin1Role == CODE_10, paPin0Role == CODE_01};
      touchKeyOneSel     <= (pbPin2Role == CODE_01);
      touchKeyTwoSel     <= (pbPin3Role == CODE_01);
      vrefSel            <= (pbPin2Role == CODE_10);
      // Interrupt follows the pin only in its general I/O codes
      extIntLevel        <= (paPin0Role == CODE_00 || paPin0Role == CODE_11)
                            ? paLevel[0] : 1'b1;
      nmosGate           <= pbOut_d[0];
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_gate_follows_pb0: assert property (pbPin0Role == CODE_01 |=>
    nmosGate == $past(timerPrimary))
    else $error("transistor gate not following timer output");

  a_pb1_inverted: assert property (pbPin1Role == CODE_01 |=>
    pbPinOut[1] == !$past(timerPrimary))
    else $error("port B pin 1 not inverted timer");

  a_pa6_inverted: assert property (paPin6Role == CODE_11 |=>
    paPinOut[6] == !$past(timerPrimary))
    else $error("port A pin 6 not inverted timer");

  a_pb0_primary: assert property (pbPin0Role == CODE_01 |=>
    pbPinOut[0] == $past(timerPrimary) && pbPinOe[0])
    else $error("port B pin 0 not driven by timer");

  a_pa1_timer: assert property (paPin1Role == CODE_11 |=>
    paPinOut[1] == $past(timerPrimary))
    else $error("port A pin 1 not driven by timer");

  a_pa0_timer: assert property (paPin0Role == CODE_10 |=>
    paPinOut[0] == $past(timerPrimary))
    else $error("port A pin 0 not driven by timer");

  a_pa2_batt: assert property (paPin2Role == CODE_10 |=>
    battSenseSel && !ampNegativeSel)
    else $error("battery sense not selected");

  a_reserved_zero: assert property (
    regRead && regAddr == OFS_PB_SEL_HIGH |=> regRdata[7:2] == 6'h00)
    else $error("reserved port B select bits not zero");

  a_pa_high_zero: assert property (
    regRead && regAddr == OFS_PA_SEL_HIGH |=> regRdata[3:2] == 2'h0)
    else $error("reserved port A select bits not zero");

  a_reset_ones: assert property (
    $fell(srst) |-> paDir_q == RST_PORT && pbData_q == RST_PORT)
    else $error("port registers not ones after reset");

endmodule : pfs_pin_function_select

// ==== test/pfs_periph_model.sv ====
`timescale 1ns/1ns
module pfs_periph_model (
  // Bench controls
  input  wire logic       tmrEn,
  input  wire logic       tmrLevel,
  input  wire logic [7:0] paExt,
  input  wire logic [7:0] pbExt,
  // Pin drive from the block
  input  wire logic [7:0] paPinOut,
  input  wire logic [7:0] paPinOe,
  input  wire logic [7:0] pbPinOut,
  input  wire logic [7:0] pbPinOe,
  // Peripheral and pad levels
  output logic            timerPrimary,
  output logic            ampOutput,
  output logic [7:0]      paPinIn,
  output logic [7:0]      pbPinIn
);
  // A stopped timer parks its output low, as the real one does when off
  assign timerPrimary = tmrEn & tmrLevel;
  assign ampOutput    = ~tmrLevel;
  // Pad level: the block wins where it drives, else the outside world
  assign paPinIn = (paPinOe & paPinOut) | (~paPinOe & paExt);
  assign pbPinIn = (pbPinOe & pbPinOut) | (~pbPinOe & pbExt);
endmodule : pfs_periph_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import pfs_pkg::*;
  logic              core_clk = 1'b0;
  logic              srst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [7:0]        regWdata = 8'h00;
  logic              regWrite = 1'b0;
  logic              regRead = 1'b0;
  logic [7:0]        regRdata;
  logic              timerPrimary, ampOutput;
  logic [7:0]        paPinIn, paPinOut, paPinOe, paAnalogEn;
  logic [7:0]        pbPinIn, pbPinOut, pbPinOe, pbAnalogEn;
  logic              ampPositiveFromPa3, ampPositiveFromPa6, ampNegativeSel;
  logic              battSenseSel, touchKeyOneSel, touchKeyTwoSel, vrefSel;
  logic              extIntLevel, nmosGate;
  logic [3:0]        analogInputSel;
  logic              tmrEn = 1'b0;
  logic              tmrLevel = 1'b0;
  logic [7:0]        paExt = 8'hFE;
  logic [7:0]        pbExt = 8'hFF;
  logic [1:0]        cc;
  logic              tl, p6, p1, p0, q1;
  int                badCount = 0;
  int                numChecks = 0;

  always #2 core_clk = ~core_clk;

  pfs_pin_function_select #(.PIN_W(8)) i_pfs_pin_function_select (
    .core_clk, .srst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
    .timerPrimary, .ampOutput, .paPinIn, .paPinOut, .paPinOe, .paAnalogEn,
    .pbPinIn, .pbPinOut, .pbPinOe, .pbAnalogEn, .ampPositiveFromPa3,
    .ampPositiveFromPa6, .ampNegativeSel, .battSenseSel, .analogInputSel,
    .touchKeyOneSel, .touchKeyTwoSel, .vrefSel, .extIntLevel, .nmosGate
  );

  pfs_periph_model i_pfs_periph_model (
    .tmrEn, .tmrLevel, .paExt, .pbExt, .paPinOut, .paPinOe, .pbPinOut,
    .pbPinOe, .timerPrimary, .ampOutput, .paPinIn, .pbPinIn
  );

  // ------------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    numChecks++;
    if (got !== exp) begin
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      badCount++;
    end
  endtask : chk

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask : regWr

  // Read data stand only in the cycle after the strobe
  task automatic regRd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(negedge core_clk);
    chk(regRdata, exp, "register read");
  endtask : regRd

  task automatic settle();
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
  endtask : settle

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    #60000;
    badCount++;
    summarize();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values of selects, latches and direction
    for (int i = 0; i < 4; i++) regRd(i[3:0], 8'h00);
    for (int i = 4; i < 8; i++) regRd(i[3:0], 8'hFF);
    chk(paPinOut & pbPinOut, 8'hFF, "pin out at reset");
    chk(paPinOe | pbPinOe, 8'h00, "pins not driven at reset");
    // Unimplemented high-select bits and an unmapped index
    // Software leaves the reserved low bits at their reset value
    regWr(OFS_PA_SEL_HIGH, 8'hFC);
    regRd(OFS_PA_SEL_HIGH, 8'hF0);
    regWr(OFS_PB_SEL_HIGH, 8'hFC);
    regRd(OFS_PB_SEL_HIGH, 8'h00);
    regWr(OFS_PA_SEL_HIGH, 8'h00);
    regWr(OFS_PB_SEL_HIGH, 8'h00);
    regWr(4'hB, 8'h5A);
    regRd(4'hB, 8'h00);
    // Every role code on every field, timer low and high
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 4; c++) begin
        cc = c[1:0];
        tl = t[0];
        @(posedge core_clk);
        tmrEn <= 1'b0;
        regWr(OFS_PA_SEL_LOW, {cc, cc, cc, cc});
        regWr(OFS_PA_SEL_HIGH, {cc, cc, 4'h0});
        regWr(OFS_PB_SEL_LOW, {cc, cc, cc, cc});
        @(posedge core_clk);
        tmrEn    <= 1'b1;
        tmrLevel <= tl;
        settle();
        chk({ampPositiveFromPa3, ampNegativeSel, battSenseSel,
             ampPositiveFromPa6, touchKeyTwoSel, touchKeyOneSel, vrefSel,
             extIntLevel},
            {cc == CODE_01, cc == CODE_01, cc == CODE_10, cc == CODE_01,
             cc == CODE_01, cc == CODE_01, cc == CODE_10,
             cc == CODE_01 || cc == CODE_10},
            "role selects");
        chk({4'h0, analogInputSel},
            {4'h0, cc == CODE_01, cc == CODE_10, cc == CODE_10,
             cc == CODE_01}, "analogue inputs");
        chk(paAnalogEn, {cc == CODE_01, cc[1] != cc[0], 2'h0, cc == CODE_01,
             cc[1] != cc[0], cc == CODE_10, cc == CODE_01},
            "port A analogue pins");
        chk(pbAnalogEn, {4'h0, cc == CODE_01, cc[1] != cc[0], 2'h0},
            "port B analogue pins");
        p6 = (cc == CODE_11);
        p1 = (cc == CODE_11) || (cc == CODE_01);
        p0 = (cc == CODE_10);
        q1 = (cc == CODE_01);
        // Amplifier output level is the inverse of the timer level here
        chk({paPinOe[6], paPinOut[6], paPinOe[1], paPinOut[1],
             paPinOe[0], paPinOut[0], pbPinOe[1], pbPinOut[1]}
            & {1'b1, p6, 1'b1, p1, 1'b1, p0, 1'b1, q1},
            {p6, ~tl, p1, q1 ? ~tl : tl, p0, tl, q1, ~tl}
            & {1'b1, p6, 1'b1, p1, 1'b1, p0, 1'b1, q1},
            "timer pins");
        chk({5'h0, pbPinOe[0], nmosGate, pbPinOut[0] & q1},
            {5'h0, q1, q1 ? tl : 1'b1, tl & q1},
            "port B pin 0 and gate");
      end
    end
    // Gate follows the data latch when pin 0 stays general I/O
    @(posedge core_clk);
    tmrEn <= 1'b0;
    regWr(OFS_PA_SEL_LOW, 8'h00);
    regWr(OFS_PA_SEL_HIGH, 8'h00);
    regWr(OFS_PB_SEL_LOW, 8'h00);
    regWr(OFS_PB_DATA, 8'hFE);
    regWr(OFS_PB_DIR, 8'hFE);
    settle();
    chk({6'h0, pbPinOe[0], nmosGate}, 8'h02, "gate from latch");
    regRd(OFS_PB_PIN, 8'hFE);
    // Pad levels read back; read-only places ignore writes
    @(posedge core_clk);
    paExt <= 8'h5A;
    settle();
    regRd(OFS_PA_PIN, 8'h5A);
    regWr(OFS_PA_PIN, 8'h00);
    regRd(OFS_PA_PIN, 8'h5A);
    @(posedge core_clk);
    tmrEn    <= 1'b1;
    tmrLevel <= 1'b1;
    settle();
    regRd(OFS_TMR_CTRL, 8'h01);
    // A second reset in mid-run restores the latched ones
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    regRd(OFS_PB_DATA, 8'hFF);
    regRd(OFS_PB_DIR, 8'hFF);
    chk({7'h0, nmosGate}, 8'h01, "gate after reset");
    summarize();
  end
endmodule : tb_top
